// ===== fbd_error_map.svh
`ifndef FBD_ERROR_MAP_SVH
`define FBD_ERROR_MAP_SVH
// byte offsets in configuration space
`define OFS_FATAL_FIRST 8'h98
`define OFS_FATAL_NEXT 8'h9c
`define OFS_NF_FIRST 8'ha0
`define OFS_NF_NEXT 8'ha4
`define OFS_REPORT_MASK 8'ha8
`define OFS_PIN0_MASK 8'hac
// writable bits
`define FATAL_FLAGS 32'h0040_0007
`define NF_FLAGS 32'h01e7_efff
`define INDEX_FIELD 32'h3000_0000
`define MASK_BITS 32'h0fff_ffff
`define MASK_RESET 32'h0fff_ffff
`define LOG_RESET 32'h0000_0000
// index field position
`define INDEX_LO 28
// fatal log bit positions
`define FAT_NRFR_BIT 22
// fatal bits whose channel low bit is meaningful; the timeout names a branch only
`define FATAL_CHAN_BITS 32'h0000_0007
// non-fatal bits whose channel low bit is meaningful
`define NF_CHAN_BITS 32'h01e6_0e00
// non-fatal bits for which index is valid
`define NF_IDX_BITS 32'h01e7_efff
`endif

// ===== fbd_error_pkg.sv
package fbd_error_pkg;
  // error source from one branch/channel
  typedef struct packed {
    logic [1:0] chan;
  } error_src_t;
  // register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cfg_req_t;
  // all state of the logger
  typedef struct packed {
    logic [31:0] fatal_first;
    logic [31:0] fatal_next;
    logic [31:0] nf_first;
    logic [31:0] nf_next;
    logic [31:0] report_mask;
    logic [31:0] pin0_mask;
    logic [31:0] rdata;
    logic err0;
  } log_state_t;
endpackage

// ===== fbd_memory_error_logging.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbd_error_map.svh"
// Function
// - later fatal errors go to next register
// - first nonfatal captured, simultaneous flags allowed
// - on ties, lowest branch, then lowest channel wins
// - index from highest set error bit
// - two-bit index at bits 29:28
// - ecc index names branch, 0 or 2
// - channel low bit only for listed errors
// - fatal next bits 22,2,1,0
// - nonfatal bits 24..17 placement
// - nonfatal ecc bits 16..0 placement
// - crc 11, config write 10, write 9
// - flags reset zero, sticky, write-one clears
// - mask zero enables, resets to one
// - mask bit n-1 for error n
// - pin0 mask gates error-0 output
// - fast reset timeout index names branch
module fbd_memory_error_logging
  import fbd_error_pkg::*;
(
  input wire logic core_clk, // core clock, 200 MHz
  input wire logic resetn, // power-good reset, active low
  input wire cfg_req_t cfg_req, // configuration access
  output logic [31:0] cfg_rdata, // read data, one cycle after rd
  input wire logic [3:0][31:0] fatal_event, // fatal pulses per channel, log layout
  input wire logic [3:0][31:0] nf_event, // nonfatal pulses per channel, log layout
  output logic err0_n // error-0 output, active low
);
  log_state_t state;
  log_state_t next_state;

  // merge the four channels of one event word
  function automatic logic [31:0] merge(input logic [3:0][31:0] ev);
    merge = ev[0] | ev[1] | ev[2] | ev[3];
  endfunction

  // index of highest error bit, lowest channel first on ties
  // reserved event bits are ignored so they can never steer the index
  function automatic logic [1:0] pick_index(input logic [3:0][31:0] ev,
                                            input logic [31:0] flag_bits,
                                            input logic [31:0] chan_bits);
    logic [1:0] idx;
    logic found;
    idx = 2'd0;
    found = 1'b0;
    for (int b = 27; b >= 0; b--) begin
      for (int c = 0; c < 4; c++) begin
        if (!found && flag_bits[b] && ev[c][b]) begin
          found = 1'b1;
          // branch only unless channel bit is meaningful
          idx = chan_bits[b] ? 2'(c) : {c[1], 1'b0};
        end
      end
    end
    pick_index = idx;
  endfunction

  // map log layout to mask layout (bit n-1 per error n)
  function automatic logic [31:0] to_mask_view(input logic [31:0] f, input logic [31:0] n);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[2:0] = f[2:0];
    m[22] = f[`FAT_NRFR_BIT];
    m[11:3] = n[8:0];
    m[14:12] = n[11:9];
    m[19:16] = n[16:13];
    m[21:20] = n[18:17];
    m[27:24] = n[24:21];
    to_mask_view = m;
  endfunction

  logic [31:0] fat_all;
  logic [31:0] nf_all;
  logic [31:0] wmask;
  logic [31:0] fat_new;
  logic [31:0] nf_new;

  // next-state logic
  always_comb begin
    next_state = state;
    fat_all = merge(fatal_event) & `FATAL_FLAGS;
    nf_all = merge(nf_event) & `NF_FLAGS;
    wmask = cfg_req.wdata;
    // write-one clear, then events set so set wins
    if (cfg_req.wr) begin
      case (cfg_req.addr)
        `OFS_FATAL_FIRST: next_state.fatal_first = state.fatal_first & ~(wmask & (`FATAL_FLAGS | `INDEX_FIELD));
        `OFS_FATAL_NEXT: next_state.fatal_next = state.fatal_next & ~(wmask & `FATAL_FLAGS);
        `OFS_NF_FIRST: next_state.nf_first = state.nf_first & ~(wmask & (`NF_FLAGS | `INDEX_FIELD));
        `OFS_NF_NEXT: next_state.nf_next = state.nf_next & ~(wmask & `NF_FLAGS);
        `OFS_REPORT_MASK: next_state.report_mask = wmask & `MASK_BITS;
        `OFS_PIN0_MASK: next_state.pin0_mask = wmask & `MASK_BITS;
        default: ;
      endcase
    end
    fat_new = fat_all;
    nf_new = nf_all;
    // fatal: first when empty, otherwise next
    if (fat_new != 32'h0000_0000) begin
      if ((state.fatal_first & `FATAL_FLAGS) == 32'h0000_0000) begin
        next_state.fatal_first = next_state.fatal_first | fat_new;
        next_state.fatal_first[29:28] = pick_index(fatal_event, `FATAL_FLAGS,
                                                   `FATAL_CHAN_BITS);
      end else begin
        next_state.fatal_next = next_state.fatal_next | fat_new;
      end
    end
    // nonfatal: same scheme
    if (nf_new != 32'h0000_0000) begin
      if ((state.nf_first & `NF_FLAGS) == 32'h0000_0000) begin
        next_state.nf_first = next_state.nf_first | nf_new;
        if ((nf_new & `NF_IDX_BITS) != 32'h0000_0000) begin
          next_state.nf_first[29:`INDEX_LO] = pick_index(nf_event, `NF_FLAGS,
                                                         `NF_CHAN_BITS);
        end
      end else begin
        next_state.nf_next = next_state.nf_next | nf_new;
      end
    end
    // error-0 output from flags enabled in both masks
    next_state.err0 = |(to_mask_view(state.fatal_first | state.fatal_next,
                                     state.nf_first | state.nf_next)
                        & ~state.report_mask & ~state.pin0_mask & `MASK_BITS);
    // registered read data
    next_state.rdata = 32'h0000_0000;
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        `OFS_FATAL_FIRST: next_state.rdata = state.fatal_first;
        `OFS_FATAL_NEXT: next_state.rdata = state.fatal_next;
        `OFS_NF_FIRST: next_state.rdata = state.nf_first;
        `OFS_NF_NEXT: next_state.rdata = state.nf_next;
        `OFS_REPORT_MASK: next_state.rdata = state.report_mask;
        `OFS_PIN0_MASK: next_state.rdata = state.pin0_mask;
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; power-good reset clears the flags and sets the masks to one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state.fatal_first <= `LOG_RESET;
      state.fatal_next <= `LOG_RESET;
      state.nf_first <= `LOG_RESET;
      state.nf_next <= `LOG_RESET;
      state.report_mask <= `MASK_RESET;
      state.pin0_mask <= `MASK_RESET;
      state.rdata <= 32'h0000_0000;
      state.err0 <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign cfg_rdata = state.rdata;
  assign err0_n = ~state.err0;
endmodule
`default_nettype wire

// ===== fbd_log_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbd_error_map.svh"
module fbd_log_chk
  import fbd_error_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic resetn, // reset, active low
  input wire cfg_req_t cfg_req, // access request
  input wire logic [31:0] cfg_rdata, // read data
  input wire logic [3:0][31:0] fatal_event, // fatal pulses
  input wire logic [3:0][31:0] nf_event, // nonfatal pulses
  input wire logic err0_n // error-0 output
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // read of one offset taken on an edge
  sequence rd_at(logic [7:0] a);
    cfg_req.rd && cfg_req.addr == a;
  endsequence
  // full mask written to one offset
  sequence mask_all(logic [7:0] a);
    cfg_req.wr && cfg_req.addr == a && cfg_req.wdata[27:0] == 28'hfff_ffff;
  endsequence
  // read data, reserved bits and error output relations
  chk_data_idle: assert property (!cfg_req.rd |=> cfg_rdata == 32'h0000_0000)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (rd_at(8'hb0) |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_fatal_reserved: assert property (rd_at(`OFS_FATAL_NEXT) |=>
    (cfg_rdata & ~`FATAL_FLAGS) == 32'h0000_0000) else $error("fatal reserved set");
  chk_nf_reserved: assert property (rd_at(`OFS_NF_FIRST) |=>
    (cfg_rdata & ~(`NF_FLAGS | `INDEX_FIELD)) == 32'h0000_0000) else $error("nf reserved set");
  chk_mask_reserved: assert property (rd_at(`OFS_PIN0_MASK) |=> cfg_rdata[31:28] == 4'h0)
    else $error("mask reserved set");
  chk_pin0_gate: assert property (mask_all(`OFS_PIN0_MASK) |=> ##1 err0_n)
    else $error("error-0 not gated by pin mask");
  chk_report_gate: assert property (mask_all(`OFS_REPORT_MASK) |=> ##1 err0_n)
    else $error("error-0 not gated by report mask");
  chk_err0_cause: assert property ($fell(err0_n) |->
    $past(cfg_req.wr || (|fatal_event) || (|nf_event), 2)) else $error("error-0 without cause");
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import fbd_error_pkg::*;;
  logic core_clk = 0, resetn = 0, err0_n, rd_seen = 0;
  cfg_req_t cfg_req = '0;
  logic [31:0] cfg_rdata, q[$];
  logic [3:0][31:0] fatal_event = '0, nf_event = '0, f = '0, n = '0;
  int bad_count = 0, comparisons = 0, seed = 91, rv;
  always #2.5 core_clk = ~core_clk;
  fbd_memory_error_logging dut_u(.core_clk(core_clk), .resetn(resetn), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .fatal_event(fatal_event), .nf_event(nf_event), .err0_n(err0_n));
  task cmp(logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t exp %h got %h", $time, e, g);
    end
  endtask
  task pin(logic e);
    @(negedge core_clk);
    cmp({31'h0, e}, {31'h0, err0_n});
  endtask
  // one access, a read notes its expected data
  task acc(logic r, logic [7:0] a, logic [31:0] d);
    if (r) q.push_back(d);
    cfg_req <= '{r, !r, a, r ? 32'h0000_0000 : d};
    @(posedge core_clk);
    cfg_req <= '0;
    @(posedge core_clk);
  endtask
  task put(logic fat, int c, int b);
    if (fat) f[c][b] = 1'b1;
    else n[c][b] = 1'b1;
  endtask
  task fire;
    fatal_event <= f;
    nf_event <= n;
    @(posedge core_clk);
    fatal_event <= '0;
    nf_event <= '0;
    f = '0;
    n = '0;
    @(posedge core_clk);
  endtask
  task stop_test;
    $display("compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // compare the oldest note whenever read data returns
  always @(posedge core_clk) begin
    if (rd_seen) cmp(q.pop_front(), cfg_rdata);
    rd_seen <= cfg_req.rd;
  end
  // watchdog
  initial begin
    #5000;
    bad_count++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
    acc(1, 8'ha8, 32'h0fff_ffff);
    acc(1, 8'hac, 32'h0fff_ffff);
    acc(1, 8'hb0, 32'h0000_0000);
    acc(0, 8'ha8, 32'h0000_0000);
    rv = $random(seed);
    acc(0, 8'hac, rv);
    acc(1, 8'hac, rv & 32'h0fff_ffff);
    acc(0, 8'hac, 32'h0000_0000);
    $display("mask test done");
    put(0, 2, 16);
    fire;
    pin(0);
    acc(1, 8'ha0, 32'h2001_0000);
    put(0, 1, 9);
    fire;
    acc(1, 8'ha4, 32'h0000_0200);
    acc(0, 8'ha4, 32'h0000_0000);
    acc(1, 8'ha4, 32'h0000_0200);
    acc(0, 8'ha4, 32'h0000_0200);
    acc(0, 8'ha0, 32'h3001_0000);
    acc(1, 8'ha0, 32'h0000_0000);
    put(0, 1, 9);
    put(0, 3, 17);
    put(0, 2, 17);
    fire;
    acc(1, 8'ha0, 32'h2002_0200);
    put(0, 0, 11);
    fire;
    acc(1, 8'ha4, 32'h0000_0800);
    put(1, 0, 0);
    fire;
    put(1, 2, 22);
    fire;
    acc(1, 8'h9c, 32'h0040_0000);
    acc(0, 8'hac, 32'h0fff_ffff);
    acc(0, 8'ha8, 32'h0fff_ffff);
    pin(1);
    $display("log test done");
    stop_test;
  end
endmodule
bind fbd_memory_error_logging fbd_log_chk chk_u(.core_clk(core_clk), .resetn(resetn),
  .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .fatal_event(fatal_event), .nf_event(nf_event),
  .err0_n(err0_n));
`default_nettype wire
